// ### czo_output_bank.sv
// Output register bank that the PLC refreshes, driving two conveyor zones
//
// Notes on behaviour
// - Tracking holds commit only at zone release
// - Both holds zero: keep active tracking
// - Both holds all-ones: clear active tracking
// - Single all-ones word is ordinary data
// - Bit zero sets zone accumulation mode
// - Bit eight accumulates next upstream zone
// - Bit nine confirms arrival, avoiding jam
// - Bits ten/eleven jog, overriding accumulation
// - Bit twelve wakes zone like status four
// - Bit thirteen maintenance holds motor stopped
// - Maintenance reports busy to upstream zone
// - Maintenance blinks sensor and motor green
// - Separate left/right speed reference registers
// - Never-written speed uses configured speed
// - Nonzero speed value becomes reference
// - Zero keeps last nonzero speed reference
// - Release value change releases accumulated carton
`timescale 1ns/1ps
`default_nettype none
`include "czo_regs.svh"

module czo_output_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Cyclic output image write port and readback port
   input wire czo_pkg::czo_wr_t wr,
   input wire logic [11:0] rdAddr,
   output logic [15:0] rdData,
   // Release registers, neighbour status and carton/arrival sensors
   input wire logic [15:0] releaseUp,
   input wire logic [15:0] releaseDn,
   input wire logic [15:0] upNeighbourStatus,
   input wire logic upCartonPresent,
   input wire logic dnCartonPresent,
   input wire logic dnArrivalSeen,
   // Configured speeds
   input wire logic [15:0] cfgLeftSpeed,
   input wire logic [15:0] cfgRightSpeed,
   // Zone outputs
   output czo_pkg::czo_motor_cmd_t upMotorCmd,
   output czo_pkg::czo_motor_cmd_t dnMotorCmd,
   output czo_pkg::czo_track_t upActiveTrack,
   output czo_pkg::czo_track_t dnActiveTrack,
   output logic upBusyToUpstream,
   output logic accumUpstreamModule,
   output logic upArrivalConfirm,
   output logic dnArrivalConfirm,
   output logic dnJam,
   // Speed references
   output logic [15:0] leftSpeedRef,
   output logic [15:0] rightSpeedRef,
   // Green indicators
   output logic upSensorIndicator,
   output logic upMotorIndicator,
   output logic dnSensorIndicator,
   output logic dnMotorIndicator
);
   import czo_pkg::*;

   localparam logic [31:0] BLINK_CYCLES = 32'(`CZO_BLINK_CYCLES);

   typedef struct packed {
      czo_track_t upHold;
      czo_track_t dnHold;
      logic [15:0] upAcc;
      logic [15:0] dnAcc;
      logic [15:0] leftSpd;
      logic [15:0] rightSpd;
      logic [15:0] leftRef;
      logic [15:0] rightRef;
      logic [15:0] relUpLast;
      logic [15:0] relDnLast;
      logic [31:0] blinkCnt;
      logic blink;
      logic dnAwaitArrival;
      logic dnJam;
      logic [15:0] rdData;
      logic upBusy;
      logic accumUpMod;
      logic upConf;
      logic dnConf;
      logic upSen;
      logic upMot;
      logic dnSen;
      logic dnMot;
      czo_motor_cmd_t upCmdOut;
      logic [15:0] leftOut;
      logic [15:0] rightOut;
   } czo_bank_state_t;

   czo_bank_state_t state_reg, state_next;
   czo_zone_ctrl_t upCtrl, dnCtrl;
   czo_track_t upActive, dnActive;
   czo_motor_cmd_t upCmd, dnCmd;
   logic upRelPulse, dnRelPulse, upBusyZone, dnBusyZone;
   logic upRelChanged, dnRelChanged;

   // ----------------------------------------------------------------------
   // Control word decode
   // ----------------------------------------------------------------------
   function automatic czo_zone_ctrl_t decode(input logic [15:0] w);
      czo_zone_ctrl_t c;
      c.accumulate = w[`CZO_ACC_MODE_BIT];
      c.accumUpstream = w[`CZO_ACC_UPSTREAM_BIT];
      c.arrivalConfirm = w[`CZO_ARRIVAL_CONF_BIT];
      c.jogFwd = w[`CZO_JOG_FWD_BIT];
      c.jogRev = w[`CZO_JOG_REV_BIT];
      c.wake = w[`CZO_WAKE_BIT];
      c.maintenance = w[`CZO_MAINT_BIT];
      return c;
   endfunction

   assign upCtrl = decode(state_reg.upAcc);
   assign dnCtrl = decode(state_reg.dnAcc);
   assign upRelChanged = releaseUp != state_reg.relUpLast;
   assign dnRelChanged = releaseDn != state_reg.relDnLast;

   // ----------------------------------------------------------------------
   // Zones
   // ----------------------------------------------------------------------
   czo_zone upZone (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .ctrl(upCtrl),
      .hold(state_reg.upHold),
      .releaseChanged(upRelChanged),
      .cartonPresent(upCartonPresent),
      // status four wakes zone like bit twelve, but only while downstream zone is not busy
      .runRequest(upNeighbourStatus == `CZO_WAKE_STATUS && !dnBusyZone),
      .active(upActive),
      .motorCmd(upCmd),
      .releasePulse(upRelPulse),
      .busyUpstream(upBusyZone)
   );

   czo_zone dnZone (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .ctrl(dnCtrl),
      .hold(state_reg.dnHold),
      .releaseChanged(dnRelChanged),
      .cartonPresent(dnCartonPresent),
      .runRequest(upRelPulse),
      .active(dnActive),
      .motorCmd(dnCmd),
      .releasePulse(dnRelPulse),
      .busyUpstream(dnBusyZone)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // every refresh simply overwrites; no change detection needed
      if (wr.we) begin
         unique case (wr.addr)
            `CZO_UP_TRK1_OFS: state_next.upHold.word1 = wr.wdata;
            `CZO_UP_TRK2_OFS: state_next.upHold.word2 = wr.wdata;
            `CZO_DN_TRK1_OFS: state_next.dnHold.word1 = wr.wdata;
            `CZO_DN_TRK2_OFS: state_next.dnHold.word2 = wr.wdata;
            `CZO_UP_ACC_OFS: state_next.upAcc = wr.wdata & `CZO_ACC_WRITE_MASK;
            `CZO_DN_ACC_OFS: state_next.dnAcc = wr.wdata & `CZO_ACC_WRITE_MASK;
            `CZO_LEFT_SPD_OFS: state_next.leftSpd = wr.wdata;
            `CZO_RIGHT_SPD_OFS: state_next.rightSpd = wr.wdata;
            default: ;
         endcase
      end
      // nonzero becomes reference; zero keeps last
      if (state_reg.leftSpd != `CZO_WORD_ZERO) begin
         state_next.leftRef = state_reg.leftSpd;
      end
      if (state_reg.rightSpd != `CZO_WORD_ZERO) begin
         state_next.rightRef = state_reg.rightSpd;
      end
      state_next.relUpLast = releaseUp;
      state_next.relDnLast = releaseDn;
      // Blink timer runs freely so both zones flash in step
      if (state_reg.blinkCnt >= BLINK_CYCLES - 32'd1) begin
         state_next.blinkCnt = '0;
         state_next.blink = !state_reg.blink;
      end else begin
         state_next.blinkCnt = state_reg.blinkCnt + 32'd1;
      end
      // jam unless arrival seen or confirmed by bit nine
      if (dnRelPulse) begin
         state_next.dnAwaitArrival = 1'b1;
         state_next.dnJam = 1'b0;
      end else if (state_reg.dnAwaitArrival && (dnArrivalSeen || dnCtrl.arrivalConfirm)) begin
         state_next.dnAwaitArrival = 1'b0;
      end else if (state_reg.dnAwaitArrival && dnCmd == CZO_MOTOR_STOP) begin
         state_next.dnAwaitArrival = 1'b0;
         state_next.dnJam = 1'b1;
      end
      state_next.upConf = upCtrl.arrivalConfirm;
      state_next.dnConf = dnCtrl.arrivalConfirm;
      state_next.upBusy = upBusyZone;
      // bit eight: downstream zone stops the local upstream; upstream zone the neighbour
      state_next.accumUpMod = upCtrl.accumUpstream;
      state_next.upSen = upCtrl.maintenance && state_reg.blink;
      state_next.upMot = upCtrl.maintenance && state_reg.blink;
      state_next.dnSen = dnCtrl.maintenance && state_reg.blink;
      state_next.dnMot = dnCtrl.maintenance && state_reg.blink;
      // local upstream zone held when downstream asks it
      if (dnCtrl.accumUpstream && upCmd == CZO_MOTOR_RUN && upCartonPresent) begin
         state_next.upCmdOut = CZO_MOTOR_STOP;
      end else begin
         state_next.upCmdOut = upCmd;
      end
      // configured speed until a nonzero reference exists
      state_next.leftOut = (state_next.leftRef == `CZO_WORD_ZERO) ? cfgLeftSpeed
         : state_next.leftRef;
      state_next.rightOut = (state_next.rightRef == `CZO_WORD_ZERO) ? cfgRightSpeed
         : state_next.rightRef;
      unique case (rdAddr)
         `CZO_UP_TRK1_OFS: state_next.rdData = state_reg.upHold.word1;
         `CZO_UP_TRK2_OFS: state_next.rdData = state_reg.upHold.word2;
         `CZO_DN_TRK1_OFS: state_next.rdData = state_reg.dnHold.word1;
         `CZO_DN_TRK2_OFS: state_next.rdData = state_reg.dnHold.word2;
         `CZO_UP_ACC_OFS: state_next.rdData = state_reg.upAcc;
         `CZO_DN_ACC_OFS: state_next.rdData = state_reg.dnAcc;
         `CZO_LEFT_SPD_OFS: state_next.rdData = state_reg.leftSpd;
         `CZO_RIGHT_SPD_OFS: state_next.rdData = state_reg.rightSpd;
         default: state_next.rdData = `CZO_WORD_ZERO;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Zone module outputs are its own flip-flops
   assign upMotorCmd = state_reg.upCmdOut;
   assign dnMotorCmd = dnCmd;
   assign upActiveTrack = upActive;
   assign dnActiveTrack = dnActive;
   assign upBusyToUpstream = state_reg.upBusy;
   assign accumUpstreamModule = state_reg.accumUpMod;
   assign upArrivalConfirm = state_reg.upConf;
   assign dnArrivalConfirm = state_reg.dnConf;
   assign dnJam = state_reg.dnJam;
   assign leftSpeedRef = state_reg.leftOut;
   assign rightSpeedRef = state_reg.rightOut;
   assign rdData = state_reg.rdData;
   assign upSensorIndicator = state_reg.upSen;
   assign upMotorIndicator = state_reg.upMot;
   assign dnSensorIndicator = state_reg.dnSen;
   assign dnMotorIndicator = state_reg.dnMot;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_left_nonzero;
      ce && state_reg.leftSpd != 16'h0000;
   endsequence
   sequence s_left_zero;
      ce && state_reg.leftSpd == 16'h0000;
   endsequence

   a_speed_zero_keeps: assert property (@(posedge clk) disable iff (rst)
      s_left_zero |=> $stable(state_reg.leftRef))
      else $error("zero speed changed reference");
   a_speed_take: assert property (@(posedge clk) disable iff (rst)
      s_left_nonzero |=> state_reg.leftRef == $past(state_reg.leftSpd))
      else $error("nonzero speed not taken");
   a_speed_default: assert property (@(posedge clk) disable iff (rst)
      (ce && state_next.rightRef == 16'h0000) |=> rightSpeedRef == $past(cfgRightSpeed))
      else $error("configured speed not used");
   a_reserved_mask: assert property (@(posedge clk) disable iff (rst)
      (state_reg.upAcc & ~16'h3F01) == 16'h0000)
      else $error("reserved control bit stored");
   a_blink_maint: assert property (@(posedge clk) disable iff (rst)
      (ce && !dnCtrl.maintenance) |=> !dnSensorIndicator)
      else $error("indicator lit outside maintenance");
   a_jam_confirm: assert property (@(posedge clk) disable iff (rst)
      (ce && state_reg.dnAwaitArrival && dnCtrl.arrivalConfirm && !dnRelPulse)
      |=> !dnJam && !state_reg.dnAwaitArrival)
      else $error("confirmation did not clear wait");
   a_accum_up: assert property (@(posedge clk) disable iff (rst)
      (ce && dnCtrl.accumUpstream && upCartonPresent) |=> upMotorCmd != CZO_MOTOR_RUN)
      else $error("upstream zone ran while held");
endmodule
`default_nettype wire

// ### czo_regs.svh
// Register offsets, field positions and timing counts for the conveyor zone output bank
`ifndef CZO_REGS_SVH
`define CZO_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (word index)
// ----------------------------------------------------------------------
`define CZO_UP_TRK1_OFS 12'h0640
`define CZO_UP_TRK2_OFS 12'h0641
`define CZO_DN_TRK1_OFS 12'h0642
`define CZO_DN_TRK2_OFS 12'h0643
`define CZO_UP_ACC_OFS 12'h0644
`define CZO_DN_ACC_OFS 12'h0645
`define CZO_LEFT_SPD_OFS 12'h0646
`define CZO_RIGHT_SPD_OFS 12'h0647

// ----------------------------------------------------------------------
// Accumulation control bit positions
// ----------------------------------------------------------------------
`define CZO_ACC_MODE_BIT 0
`define CZO_ACC_UPSTREAM_BIT 8
`define CZO_ARRIVAL_CONF_BIT 9
`define CZO_JOG_FWD_BIT 10
`define CZO_JOG_REV_BIT 11
`define CZO_WAKE_BIT 12
`define CZO_MAINT_BIT 13
`define CZO_ACC_WRITE_MASK 16'h3F01

// ----------------------------------------------------------------------
// Reset values and reserved codes
// ----------------------------------------------------------------------
`define CZO_WORD_ZERO 16'h0000
`define CZO_TRK_KEEP 16'h0000
`define CZO_TRK_CLEAR 16'hFFFF
`define CZO_WAKE_STATUS 16'h0004

// ----------------------------------------------------------------------
// Timing: maintenance indicator blink half period
// ----------------------------------------------------------------------
`define CZO_BLINK_MS 500
`define CZO_CLK_MHZ 100
`define CZO_BLINK_CYCLES (`CZO_BLINK_MS * 1000 * `CZO_CLK_MHZ)

`endif

// ### czo_pkg.sv
// Types shared by the conveyor zone output bank
package czo_pkg;

   typedef struct packed {
      logic [15:0] word1;
      logic [15:0] word2;
   } czo_track_t;

   typedef struct packed {
      logic accumulate;
      logic accumUpstream;
      logic arrivalConfirm;
      logic jogFwd;
      logic jogRev;
      logic wake;
      logic maintenance;
   } czo_zone_ctrl_t;

   typedef enum logic [1:0] {
      CZO_MOTOR_STOP = 2'b00,
      CZO_MOTOR_RUN = 2'b01,
      CZO_MOTOR_JOG_FWD = 2'b10,
      CZO_MOTOR_JOG_REV = 2'b11
   } czo_motor_cmd_t;

   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [15:0] wdata;
   } czo_wr_t;

endpackage

// ### czo_zone.sv
// One zone: tracking commit on release and motor command arbitration
`timescale 1ns/1ps
`default_nettype none
`include "czo_regs.svh"

module czo_zone (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire czo_pkg::czo_zone_ctrl_t ctrl,
   input wire czo_pkg::czo_track_t hold,
   input wire logic releaseChanged,
   input wire logic cartonPresent,
   input wire logic runRequest,
   // Results
   output czo_pkg::czo_track_t active,
   output czo_pkg::czo_motor_cmd_t motorCmd,
   output logic releasePulse,
   output logic busyUpstream
);
   import czo_pkg::*;

   typedef struct packed {
      czo_track_t active;
      czo_motor_cmd_t motorCmd;
      logic releasePulse;
      logic busyUpstream;
   } czo_zone_state_t;

   czo_zone_state_t state_reg, state_next;
   logic releaseNow;

   always_comb begin
      state_next = state_reg;
      releaseNow = ctrl.accumulate && releaseChanged && !ctrl.maintenance;
      state_next.releasePulse = releaseNow;
      if (releaseNow) begin
         if (hold.word1 == `CZO_TRK_KEEP && hold.word2 == `CZO_TRK_KEEP) begin
            state_next.active = state_reg.active;
         end else if (hold.word1 == `CZO_TRK_CLEAR && hold.word2 == `CZO_TRK_CLEAR) begin
            state_next.active = '0;
         // commit on release; lone ones is data
         end else begin
            state_next.active = hold;
         end
      end
      // maintenance stops motor; jog beats logic
      if (ctrl.maintenance) begin
         state_next.motorCmd = CZO_MOTOR_STOP;
      end else if (ctrl.jogFwd) begin
         state_next.motorCmd = CZO_MOTOR_JOG_FWD;
      end else if (ctrl.jogRev) begin
         state_next.motorCmd = CZO_MOTOR_JOG_REV;
      end else if (ctrl.wake || runRequest || releaseNow) begin
         state_next.motorCmd = CZO_MOTOR_RUN;
      end else if (ctrl.accumulate && cartonPresent) begin
         state_next.motorCmd = CZO_MOTOR_STOP;
      end else begin
         state_next.motorCmd = state_reg.motorCmd;
      end
      state_next.busyUpstream = ctrl.maintenance;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign active = state_reg.active;
   assign motorCmd = state_reg.motorCmd;
   assign releasePulse = state_reg.releasePulse;
   assign busyUpstream = state_reg.busyUpstream;

   a_maint_stop: assert property (@(posedge clk) disable iff (rst)
      (ce && ctrl.maintenance) |=> motorCmd == CZO_MOTOR_STOP)
      else $error("motor not stopped in maintenance");
   a_clear_code: assert property (@(posedge clk) disable iff (rst)
      (ce && releaseNow && hold.word1 == `CZO_TRK_CLEAR && hold.word2 == `CZO_TRK_CLEAR)
      |=> active == '0)
      else $error("clear code did not clear tracking");
   a_keep_code: assert property (@(posedge clk) disable iff (rst)
      (ce && releaseNow && hold == '0) |=> $stable(active))
      else $error("keep code changed tracking");
   a_commit_data: assert property (@(posedge clk) disable iff (rst)
      (ce && releaseNow && hold != '0 && !(hold.word1 == `CZO_TRK_CLEAR
      && hold.word2 == `CZO_TRK_CLEAR)) |=> active == $past(hold))
      else $error("tracking not committed");
   a_jog_prio: assert property (@(posedge clk) disable iff (rst)
      (ce && !ctrl.maintenance && ctrl.jogFwd) |=> motorCmd == CZO_MOTOR_JOG_FWD)
      else $error("jog did not override");
   a_busy_up: assert property (@(posedge clk) disable iff (rst)
      ce |=> busyUpstream == $past(ctrl.maintenance))
      else $error("busy not following maintenance");
endmodule
`default_nettype wire

// ### czo_plc_model.sv
// Behavioural model of the PLC that refreshes the cyclic output image
`timescale 1ns/1ps
`default_nettype none
`include "czo_regs.svh"

module czo_plc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Output image held by PLC logic
   input wire logic [7:0][15:0] image,
   // Cyclic write toward the bank
   output czo_pkg::czo_wr_t wr
);
   import czo_pkg::*;

   logic [2:0] idx;

   initial begin
      wr = '0;
      idx = 3'h0;
   end

   // ----------------------------------------------------------------------
   // Cyclic refresh
   // ----------------------------------------------------------------------
   // whole image refresh
   // Every word is rewritten each pass, never only on change, as a real scan does
   always @(negedge clk) begin
      if (rst) begin
         wr <= '0;
         idx <= 3'h0;
      end else begin
         wr.we <= 1'b1;
         wr.addr <= `CZO_UP_TRK1_OFS + {9'h000, idx};
         wr.wdata <= image[idx];
         idx <= idx + 3'h1;
      end
   end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the conveyor zone output bank
`timescale 1ns/1ps
`default_nettype none
`include "czo_regs.svh"

module testbench;
   import czo_pkg::*;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] rd;
      czo_motor_cmd_t motor;
      logic chkMotor;
      logic busy;
      logic accUp;
      logic conf;
   } czo_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0][15:0] image = '0;
   czo_wr_t wr;
   logic [11:0] rdAddr = 12'h000;
   logic [15:0] rdData;
   logic [15:0] releaseUp = 16'h0000;
   logic [15:0] releaseDn = 16'h0000;
   logic [15:0] upNeighbourStatus = 16'h0000;
   logic upCartonPresent = 1'b0;
   logic dnCartonPresent = 1'b0;
   logic dnArrivalSeen = 1'b0;
   logic [15:0] cfgLeftSpeed = 16'h0123;
   logic [15:0] cfgRightSpeed = 16'h0456;
   czo_motor_cmd_t upMotorCmd;
   czo_motor_cmd_t dnMotorCmd;
   czo_track_t upActiveTrack;
   czo_track_t dnActiveTrack;
   logic upBusyToUpstream;
   logic accumUpstreamModule;
   logic upArrivalConfirm;
   logic dnArrivalConfirm;
   logic dnJam;
   logic [15:0] leftSpeedRef;
   logic [15:0] rightSpeedRef;
   logic upSensorIndicator;
   logic upMotorIndicator;
   logic dnSensorIndicator;
   logic dnMotorIndicator;
   int fail_count = 0;
   int comparisons = 0;
   logic [1:0][31:0] trackExp = '0;
   czo_row_t rows [9];

   always #5 clk = ~clk;

   czo_output_bank u_czo_output_bank (
      .clk(clk), .rst(rst), .ce(ce), .wr(wr), .rdAddr(rdAddr), .rdData(rdData),
      .releaseUp(releaseUp), .releaseDn(releaseDn), .upNeighbourStatus(upNeighbourStatus),
      .upCartonPresent(upCartonPresent), .dnCartonPresent(dnCartonPresent),
      .dnArrivalSeen(dnArrivalSeen), .cfgLeftSpeed(cfgLeftSpeed),
      .cfgRightSpeed(cfgRightSpeed), .upMotorCmd(upMotorCmd), .dnMotorCmd(dnMotorCmd),
      .upActiveTrack(upActiveTrack), .dnActiveTrack(dnActiveTrack),
      .upBusyToUpstream(upBusyToUpstream), .accumUpstreamModule(accumUpstreamModule),
      .upArrivalConfirm(upArrivalConfirm), .dnArrivalConfirm(dnArrivalConfirm),
      .dnJam(dnJam), .leftSpeedRef(leftSpeedRef), .rightSpeedRef(rightSpeedRef),
      .upSensorIndicator(upSensorIndicator), .upMotorIndicator(upMotorIndicator),
      .dnSensorIndicator(dnSensorIndicator), .dnMotorIndicator(dnMotorIndicator)
   );

   czo_plc_model u_czo_plc_model (.clk(clk), .rst(rst), .image(image), .wr(wr));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Wait n cycles; twelve cover one full image pass plus register and output stages
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic release_zone(input logic dn, input logic [15:0] h1,
                               input logic [15:0] h2, input logic [31:0] exp);
      image[dn ? 2 : 0] = h1;
      image[dn ? 3 : 1] = h2;
      wait_cyc(12);
      check(dn ? dnActiveTrack : upActiveTrack, trackExp[dn]);
      if (dn) releaseDn = releaseDn + 16'h0001;
      else releaseUp = releaseUp + 16'h0001;
      trackExp[dn] = exp;
      wait_cyc(6);
      check(dn ? dnActiveTrack : upActiveTrack, trackExp[dn]);
   endtask

   task automatic give_verdict();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------------
   // Tests need well under two thousand cycles
   initial begin
      #(20000 * 10);
      fail_count++;
      $display("watchdog expired at %0t", $time);
      give_verdict();
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rows = '{
         '{16'h0400, 16'h0400, CZO_MOTOR_JOG_FWD, 1'b1, 1'b0, 1'b0, 1'b0},
         '{16'h0800, 16'h0800, CZO_MOTOR_JOG_REV, 1'b1, 1'b0, 1'b0, 1'b0},
         '{16'h0C00, 16'h0C00, CZO_MOTOR_JOG_FWD, 1'b1, 1'b0, 1'b0, 1'b0},
         '{16'h1000, 16'h1000, CZO_MOTOR_RUN, 1'b1, 1'b0, 1'b0, 1'b0},
         '{16'h2000, 16'h2000, CZO_MOTOR_STOP, 1'b1, 1'b1, 1'b0, 1'b0},
         '{16'h0100, 16'h0100, CZO_MOTOR_STOP, 1'b0, 1'b0, 1'b1, 1'b0},
         '{16'h0200, 16'h0200, CZO_MOTOR_STOP, 1'b0, 1'b0, 1'b0, 1'b1},
         '{16'hFFFF, 16'h3F01, CZO_MOTOR_STOP, 1'b0, 1'b1, 1'b1, 1'b1},
         '{16'hC0FE, 16'h0000, CZO_MOTOR_STOP, 1'b0, 1'b0, 1'b0, 1'b0}};
      wait_cyc(3);
      rst = 1'b0;
      wait_cyc(1);
      check(32'(leftSpeedRef), {16'h0000, cfgLeftSpeed});
      check(32'(rightSpeedRef), {16'h0000, cfgRightSpeed});
      check(upActiveTrack, 32'h0000_0000);
      $display("test reset done");
      // Control word rows on the upstream zone, read back as well
      rdAddr = `CZO_UP_ACC_OFS;
      foreach (rows[i]) begin
         image[4] = rows[i].ctrl;
         wait_cyc(12);
         check(32'(rdData), 32'(rows[i].rd));
         if (rows[i].chkMotor) check(32'(upMotorCmd), 32'(rows[i].motor));
         check(32'(upBusyToUpstream), 32'(rows[i].busy));
         check(32'(accumUpstreamModule), 32'(rows[i].accUp));
         check(32'(upArrivalConfirm), 32'(rows[i].conf));
      end
      $display("test control rows done");
      image[4] = 16'h0000;
      image[5] = 16'h0600;
      upNeighbourStatus = `CZO_WAKE_STATUS;
      rdAddr = 12'h0648;
      wait_cyc(12);
      check(32'(upMotorCmd), 32'(CZO_MOTOR_RUN));
      check(32'(dnMotorCmd), 32'(CZO_MOTOR_JOG_FWD));
      check(32'(dnArrivalConfirm), 32'h0000_0001);
      check(32'(rdData), 32'h0000_0000);
      upNeighbourStatus = 16'h0000;
      $display("test neighbour and downstream done");
      // Speed references, zero keeps the last nonzero one
      image[6] = 16'h0190;
      wait_cyc(12);
      check(32'(leftSpeedRef), 32'h0000_0190);
      check(32'(rightSpeedRef), {16'h0000, cfgRightSpeed});
      image[6] = 16'h0000;
      image[7] = 16'h0FA0;
      wait_cyc(12);
      check(32'(leftSpeedRef), 32'h0000_0190);
      check(32'(rightSpeedRef), 32'h0000_0FA0);
      image[6] = 16'h00C8;
      wait_cyc(12);
      check(32'(leftSpeedRef), 32'h0000_00C8);
      $display("test speed done");
      // Tracking commit on release, accumulation on in both zones
      image[4] = 16'h0001;
      image[5] = 16'h0001;
      upCartonPresent = 1'b1;
      dnCartonPresent = 1'b1;
      wait_cyc(12);
      release_zone(1'b0, 16'h1234, 16'hFFFF, 32'h1234_FFFF);
      release_zone(1'b0, 16'h0000, 16'h0000, 32'h1234_FFFF);
      release_zone(1'b0, 16'hFFFF, 16'hFFFF, 32'h0000_0000);
      release_zone(1'b1, 16'hFFFF, 16'h00A5, 32'hFFFF_00A5);
      release_zone(1'b1, 16'hFFFF, 16'hFFFF, 32'h0000_0000);
      check(32'(dnJam), 32'h0000_0001);
      image[5] = 16'h0201;
      wait_cyc(12);
      release_zone(1'b1, 16'h0011, 16'h0022, 32'h0011_0022);
      check(32'(dnJam), 32'h0000_0000);
      check(32'({upSensorIndicator, upMotorIndicator, dnSensorIndicator,
         dnMotorIndicator}), 32'h0000_0000);
      $display("test tracking done");
      give_verdict();
   end
endmodule
`default_nettype wire
